// ===== core/ifcd_pkg.sv
// Constants, types and helpers for the instruction format and cycle decoder
// Assumes 24-bit instruction words and one instruction cycle per word
package ifcd_pkg;
  // Word layout
  localparam int WORD_W   = 24;
  localparam int OPC_W    = 8;
  localparam int OPC_LSB  = 16;
  localparam int REG_W    = 4;
  localparam int MODE_W   = 2;
  localparam int FADDR_W  = 13;
  localparam int LIT_W    = 16;
  localparam int PADDR_W  = 23;
  localparam int EXT_LO_W = 7;
  localparam int ALIT_W   = 6;
  // Opcodes
  localparam logic [7:0] OPC_NOP      = 8'h00;
  localparam logic [7:0] OPC_BRA      = 8'h01;
  localparam logic [7:0] OPC_BRA_COMP = 8'h02;
  localparam logic [7:0] OPC_BR_COND  = 8'h03;
  localparam logic [7:0] OPC_CALL_IND = 8'h04;
  localparam logic [7:0] OPC_GOTO_IND = 8'h05;
  localparam logic [7:0] OPC_RETURN   = 8'h06;
  localparam logic [7:0] OPC_RETURN_FROM_INTERRUPT_INSTR   = 8'h07;
  localparam logic [7:0] OPC_TBL_RD   = 8'h08;
  localparam logic [7:0] OPC_TBL_WR   = 8'h09;
  localparam logic [7:0] OPC_GOTO_DW  = 8'h0A;
  localparam logic [7:0] OPC_CALL_DW  = 8'h0B;
  localparam logic [7:0] OPC_MOV_DW   = 8'h0C;
  // Opcode group bits
  localparam logic [1:0] GRP_CONTROL = 2'h0;
  localparam logic [1:0] GRP_WORD    = 2'h1;
  localparam logic [1:0] GRP_BITLIT  = 2'h2;
  localparam logic [1:0] GRP_DSP     = 2'h3;
  localparam int GRP_LSB  = 6;
  localparam int BIT_SEL  = 5;
  localparam int SUB_SEL  = 4;
  localparam int LIT_TGT  = 0;
  // Operand field positions
  localparam int BASE_LSB   = 12;
  localparam int DMODE_LSB  = 10;
  localparam int DST_LSB    = 6;
  localparam int SMODE_LSB  = 4;
  localparam int SRC_LSB    = 0;
  localparam int BYTE_POS   = 14;
  localparam int FDEST_POS  = 15;
  localparam int BITREG_POS = 11;
  localparam int BITFILE_POS = 10;
  localparam int TBL_LSB    = 14;
  localparam logic [1:0] MODE_DIRECT = 2'h0;
  // Cycle counts
  localparam logic [1:0] CYC_ONE   = 2'h1;
  localparam logic [1:0] CYC_TWO   = 2'h2;
  localparam logic [1:0] CYC_THREE = 2'h3;
  // Status flag masks, bits C DC N OV Z from low to high
  localparam logic [4:0] FLAGS_ALL  = 5'h1F;
  localparam logic [4:0] FLAGS_ZERO = 5'h10;
  localparam logic [4:0] FLAGS_NONE = 5'h00;

  typedef enum logic [2:0] {
    CAT_WORD_BYTE, CAT_BIT, CAT_LITERAL, CAT_DSP, CAT_CONTROL
  } ifcd_cat_type;

  function automatic logic ifcd_is_double(input logic [7:0] op);
    return (op == OPC_GOTO_DW) || (op == OPC_CALL_DW) || (op == OPC_MOV_DW);
  endfunction
endpackage

// ===== core/ifcd_dec_if.sv
// Interface carrying one instruction word and its decoded fields
// Assumes the top module drives the word and the leaves decode it
`timescale 1ns/1ps
`default_nettype none
interface ifcd_dec_if;
  logic [23:0]                word;
  logic [7:0]                 opcode;
  ifcd_pkg::ifcd_cat_type     cat;
  logic                       is_double;
  logic                       is_skip;
  logic                       is_cond_br;
  logic [1:0]                 fixed_cyc;
  logic [4:0]                 flag_mask;
  logic [3:0]                 base;
  logic [3:0]                 src;
  logic [3:0]                 dst;
  logic [1:0]                 src_mode;
  logic [1:0]                 dst_mode;
  logic [12:0]                file_addr;
  logic                       dest_is_file;
  logic [3:0]                 bit_pos;
  logic                       bit_from_reg;
  logic [15:0]                lit;
  logic                       lit_wr_dst;
  logic [1:0]                 tbl_mode;
  logic                       byte_mode;

  modport cls_mp (input word, output opcode, cat, is_double, is_skip,
                  is_cond_br, fixed_cyc, flag_mask);
  modport spl_mp (input word, opcode, cat, output base, src, dst, src_mode,
                  dst_mode, file_addr, dest_is_file, bit_pos, bit_from_reg,
                  lit, lit_wr_dst, tbl_mode, byte_mode);
endinterface
`default_nettype wire

// ===== core/ifcd_classify.sv
// Opcode classifier: category, word count, cycle class, flag mask
// Assumes a combinational path from the word held in the interface
`timescale 1ns/1ps
`default_nettype none
module ifcd_classify (
  // Decoded fields
  ifcd_dec_if.cls_mp dec
);
  logic [7:0] op;

  assign op = dec.word[ifcd_pkg::OPC_LSB +: ifcd_pkg::OPC_W];

  always_comb begin
    dec.opcode     = op;
    dec.is_double  = ifcd_pkg::ifcd_is_double(op);
    dec.is_cond_br = (op == ifcd_pkg::OPC_BR_COND);
    dec.is_skip    = 1'b0;
    dec.flag_mask  = ifcd_pkg::FLAGS_NONE;
    dec.cat        = ifcd_pkg::CAT_CONTROL;
    case (op[ifcd_pkg::GRP_LSB +: 2])
      ifcd_pkg::GRP_WORD: begin
        dec.cat       = ifcd_pkg::CAT_WORD_BYTE;
        dec.flag_mask = ifcd_pkg::FLAGS_ALL;
      end
      ifcd_pkg::GRP_BITLIT: begin
        if (op[ifcd_pkg::BIT_SEL]) begin
          dec.cat       = ifcd_pkg::CAT_BIT;
          dec.is_skip   = op[ifcd_pkg::SUB_SEL];
          dec.flag_mask = ifcd_pkg::FLAGS_ZERO;
        end else begin
          dec.cat = ifcd_pkg::CAT_LITERAL;
          if (op[ifcd_pkg::SUB_SEL]) begin
            dec.flag_mask = ifcd_pkg::FLAGS_ALL;
          end
        end
      end
      ifcd_pkg::GRP_DSP: begin
        dec.cat       = ifcd_pkg::CAT_DSP;
        dec.flag_mask = ifcd_pkg::FLAGS_ALL;
      end
      default: dec.cat = ifcd_pkg::CAT_CONTROL;
    endcase
    // Fixed cycle cost before any condition
    case (op)
      ifcd_pkg::OPC_GOTO_DW, ifcd_pkg::OPC_CALL_DW,
      ifcd_pkg::OPC_MOV_DW:   dec.fixed_cyc = ifcd_pkg::CYC_TWO;
      ifcd_pkg::OPC_BRA, ifcd_pkg::OPC_BRA_COMP, ifcd_pkg::OPC_CALL_IND,
      ifcd_pkg::OPC_GOTO_IND, ifcd_pkg::OPC_TBL_RD,
      ifcd_pkg::OPC_TBL_WR:   dec.fixed_cyc = ifcd_pkg::CYC_TWO;
      ifcd_pkg::OPC_RETURN,
      ifcd_pkg::OPC_RETURN_FROM_INTERRUPT_INSTR:   dec.fixed_cyc = ifcd_pkg::CYC_THREE;
      default:                dec.fixed_cyc = ifcd_pkg::CYC_ONE;
    endcase
  end
endmodule // ifcd_classify
`default_nettype wire

// ===== core/ifcd_field_split.sv
// Operand field splitter for single-location instruction words
// Assumes opcode and category come from the classifier
`timescale 1ns/1ps
`default_nettype none
module ifcd_field_split (
  // Decoded fields
  ifcd_dec_if.spl_mp dec
);
  logic [15:0] w;

  assign w = dec.word[15:0];

  always_comb begin
    dec.base         = w[ifcd_pkg::BASE_LSB +: ifcd_pkg::REG_W];
    dec.src          = w[ifcd_pkg::SRC_LSB +: ifcd_pkg::REG_W];
    dec.dst          = w[ifcd_pkg::DST_LSB +: ifcd_pkg::REG_W];
    dec.src_mode     = w[ifcd_pkg::SMODE_LSB +: ifcd_pkg::MODE_W];
    dec.dst_mode     = w[ifcd_pkg::DMODE_LSB +: ifcd_pkg::MODE_W];
    dec.file_addr    = 13'h0000;
    dec.dest_is_file = 1'b0;
    dec.bit_pos      = w[ifcd_pkg::BASE_LSB +: ifcd_pkg::REG_W];
    dec.bit_from_reg = 1'b0;
    dec.lit          = 16'h0000;
    dec.lit_wr_dst   = 1'b0;
    dec.tbl_mode     = 2'h0;
    dec.byte_mode    = 1'b0;
    case (dec.cat)
      ifcd_pkg::CAT_WORD_BYTE: begin
        dec.byte_mode = w[ifcd_pkg::BYTE_POS];
        if (dec.opcode[ifcd_pkg::SUB_SEL]) begin
          dec.file_addr    = w[ifcd_pkg::FADDR_W-1:0];
          dec.dest_is_file = w[ifcd_pkg::FDEST_POS];
        end
      end
      ifcd_pkg::CAT_BIT: begin
        dec.bit_from_reg = w[ifcd_pkg::BITREG_POS];
        dec.dest_is_file = w[ifcd_pkg::BITFILE_POS];
        dec.file_addr    = {3'h0, w[9:0]};
      end
      ifcd_pkg::CAT_LITERAL: begin
        if (dec.opcode[ifcd_pkg::SUB_SEL]) begin
          dec.lit        = {10'h000, w[ifcd_pkg::ALIT_W-1:0]};
          dec.lit_wr_dst = (dec.dst != dec.base) ||
                           (dec.dst_mode != ifcd_pkg::MODE_DIRECT);
        end else if (dec.opcode[ifcd_pkg::LIT_TGT]) begin
          dec.dest_is_file = 1'b1;
          dec.file_addr    = {5'h00, w[7:0]};
          dec.lit          = {8'h00, w[15:8]};
        end else begin
          dec.base = w[ifcd_pkg::SRC_LSB +: ifcd_pkg::REG_W];
          dec.lit  = {4'h0, w[15:4]};
        end
      end
      ifcd_pkg::CAT_CONTROL: begin
        dec.lit = w;
        if (dec.opcode == ifcd_pkg::OPC_TBL_RD ||
            dec.opcode == ifcd_pkg::OPC_TBL_WR) begin
          dec.tbl_mode = w[ifcd_pkg::TBL_LSB +: 2];
        end
      end
      default: dec.lit = 16'h0000;
    endcase
  end
endmodule // ifcd_field_split
`default_nettype wire

// ===== core/ifcd_decoder.sv
// Top of the instruction format and cycle decoder
// Assumes program memory presents one word per instruction cycle
`timescale 1ns/1ps
`default_nettype none
module ifcd_decoder (
  // Clock, reset, enable
  input  wire logic                   clk_sys_in,
  input  wire logic                   reset_in,
  input  wire logic                   clk_en_in,
  // Program memory side
  input  wire logic [23:0]            insn_word_in,
  input  wire logic                   insn_valid_in,
  input  wire logic                   cond_true_in,
  // Cycle sequencing
  output logic                        slot_valid_out,
  output logic                        exec_out,
  output logic                        nop_out,
  output logic                        done_out,
  output logic [1:0]                  cycles_out,
  // Second word
  output logic                        ext_valid_out,
  output logic [15:0]                 ext_word_out,
  output logic [22:0]                 prog_addr_out,
  output logic                        dw_fault_out,
  // Decoded fields
  output ifcd_pkg::ifcd_cat_type      category_out,
  output logic [7:0]                  opcode_out,
  output logic [3:0]                  base_reg_out,
  output logic [3:0]                  src_reg_out,
  output logic [1:0]                  src_mode_out,
  output logic [3:0]                  dst_reg_out,
  output logic [1:0]                  dst_mode_out,
  output logic [12:0]                 file_addr_out,
  output logic                        dest_is_file_out,
  output logic [3:0]                  bit_pos_out,
  output logic                        bit_from_reg_out,
  output logic [15:0]                 literal_out,
  output logic                        lit_wr_dst_out,
  output logic [1:0]                  table_mode_out,
  output logic [4:0]                  flag_mask_out,
  output logic                        byte_mode_out
);
  typedef enum logic [2:0] {
    ST_ISSUE, ST_SECOND, ST_FLUSH, ST_SKIP, ST_SKIP_DW
  } ifcd_state_type;

  ifcd_state_type state_ff;
  ifcd_state_type nxt_state;
  logic [1:0]     left_ff;
  logic [1:0]     nxt_left;
  logic [1:0]     cnt_ff;
  logic [1:0]     nxt_cnt;
  logic [1:0]     extra;
  logic           step;
  logic           issue;
  logic           done;
  logic [7:0]     in_opc;

  ifcd_dec_if dec_if ();

  assign dec_if.word = insn_word_in;
  assign in_opc      = insn_word_in[ifcd_pkg::OPC_LSB +: ifcd_pkg::OPC_W];

  ifcd_classify u_classify (
    .dec (dec_if.cls_mp)
  );

  ifcd_field_split u_split (
    .dec (dec_if.spl_mp)
  );

  // One accepted word is one instruction cycle
  assign step  = clk_en_in && insn_valid_in;
  assign issue = step && (state_ff == ST_ISSUE);

  // Extra no-operation cycles after the first
  always_comb begin
    if (dec_if.is_cond_br && cond_true_in) begin
      extra = 2'h1;
    end else begin
      extra = 2'(dec_if.fixed_cyc - ifcd_pkg::CYC_ONE);
    end
  end

  // Cycle sequencer
  always_comb begin
    nxt_state = state_ff;
    nxt_left  = left_ff;
    done      = 1'b0;
    if (step) begin
      case (state_ff)
        ST_ISSUE: begin
          if (dec_if.is_double) begin
            nxt_state = ST_SECOND;
          end else if (dec_if.is_skip && cond_true_in) begin
            nxt_state = ST_SKIP;
          end else if (extra != 2'h0) begin
            nxt_state = ST_FLUSH;
            nxt_left  = extra;
          end else begin
            done = 1'b1;
          end
        end
        ST_SECOND: begin
          nxt_state = ST_ISSUE;
          done      = 1'b1;
        end
        ST_FLUSH: begin
          if (left_ff == 2'h1) begin
            nxt_state = ST_ISSUE;
            done      = 1'b1;
          end else begin
            nxt_left = 2'(left_ff - 2'h1);
          end
        end
        ST_SKIP: begin
          if (dec_if.is_double) begin
            nxt_state = ST_SKIP_DW;
          end else begin
            nxt_state = ST_ISSUE;
            done      = 1'b1;
          end
        end
        ST_SKIP_DW: begin
          nxt_state = ST_ISSUE;
          done      = 1'b1;
        end
        default: nxt_state = ST_ISSUE;
      endcase
    end
  end

  assign nxt_cnt = issue ? ifcd_pkg::CYC_ONE : 2'(cnt_ff + 2'h1);

  // Sequencer state
  always_ff @(posedge clk_sys_in or posedge reset_in) begin
    if (reset_in) begin
      state_ff <= ST_ISSUE;
      left_ff  <= 2'h0;
      cnt_ff   <= 2'h0;
    end else if (clk_en_in) begin
      state_ff <= nxt_state;
      left_ff  <= nxt_left;
      if (step) begin
        cnt_ff <= nxt_cnt;
      end
    end
  end

  // Per-cycle pulses
  always_ff @(posedge clk_sys_in or posedge reset_in) begin
    if (reset_in) begin
      slot_valid_out <= 1'b0;
      exec_out       <= 1'b0;
      nop_out        <= 1'b0;
      done_out       <= 1'b0;
      cycles_out     <= 2'h0;
    end else if (clk_en_in) begin
      slot_valid_out <= step;
      exec_out       <= issue;
      // Flush, annulled and lone second words do nothing
      nop_out <= step && ((state_ff == ST_FLUSH) || (state_ff == ST_SKIP) ||
                          (state_ff == ST_SKIP_DW) ||
                          (issue && in_opc == ifcd_pkg::OPC_NOP));
      done_out <= done;
      if (done) begin
        cycles_out <= nxt_cnt;
      end
    end
  end

  // Second word of a double-location instruction
  always_ff @(posedge clk_sys_in or posedge reset_in) begin
    if (reset_in) begin
      ext_valid_out <= 1'b0;
      ext_word_out  <= 16'h0000;
      prog_addr_out <= 23'h000000;
      dw_fault_out  <= 1'b0;
    end else if (clk_en_in) begin
      ext_valid_out <= step && (state_ff == ST_SECOND);
      dw_fault_out  <= step && (state_ff == ST_SECOND) &&
                       (in_opc != ifcd_pkg::OPC_NOP);
      if (step && (state_ff == ST_SECOND)) begin
        ext_word_out  <= insn_word_in[15:0];
        prog_addr_out <= {insn_word_in[ifcd_pkg::EXT_LO_W-1:0],
                          literal_out};
      end
    end
  end

  // Decoded fields, held until the next issue
  always_ff @(posedge clk_sys_in or posedge reset_in) begin
    if (reset_in) begin
      category_out     <= ifcd_pkg::CAT_CONTROL;
      opcode_out       <= ifcd_pkg::OPC_NOP;
      base_reg_out     <= 4'h0;
      src_reg_out      <= 4'h0;
      src_mode_out     <= 2'h0;
      dst_reg_out      <= 4'h0;
      dst_mode_out     <= 2'h0;
      file_addr_out    <= 13'h0000;
      dest_is_file_out <= 1'b0;
      bit_pos_out      <= 4'h0;
      bit_from_reg_out <= 1'b0;
      literal_out      <= 16'h0000;
      lit_wr_dst_out   <= 1'b0;
      table_mode_out   <= 2'h0;
      flag_mask_out    <= ifcd_pkg::FLAGS_NONE;
      byte_mode_out    <= 1'b0;
    end else if (clk_en_in && issue) begin
      category_out     <= dec_if.cat;
      opcode_out       <= dec_if.opcode;
      base_reg_out     <= dec_if.base;
      src_reg_out      <= dec_if.src;
      src_mode_out     <= dec_if.src_mode;
      dst_reg_out      <= dec_if.dst;
      dst_mode_out     <= dec_if.dst_mode;
      file_addr_out    <= dec_if.file_addr;
      dest_is_file_out <= dec_if.dest_is_file;
      bit_pos_out      <= dec_if.bit_pos;
      bit_from_reg_out <= dec_if.bit_from_reg;
      literal_out      <= dec_if.lit;
      lit_wr_dst_out   <= dec_if.lit_wr_dst;
      table_mode_out   <= dec_if.tbl_mode;
      flag_mask_out    <= dec_if.flag_mask;
      byte_mode_out    <= dec_if.byte_mode;
    end
  end

  // Checks
  default clocking cb @(posedge clk_sys_in);
  endclocking
  default disable iff (reset_in);

  property p_word_slot;
    step |=> slot_valid_out;
  endproperty
  a_word_slot: assert property (p_word_slot)
    else $error("accepted word did not take a slot");

  property p_two_word_only_listed;
    step && state_ff == ST_SECOND |=> ifcd_pkg::ifcd_is_double(opcode_out);
  endproperty
  a_two_word_only_listed: assert property (p_two_word_only_listed)
    else $error("second word taken for a single-word opcode");

  property p_opcode_split;
    issue |=> exec_out && opcode_out == $past(in_opc);
  endproperty
  a_opcode_split: assert property (p_opcode_split)
    else $error("opcode field not taken from the upper eight bits");

  property p_second_hi_zero;
    step && state_ff == ST_SECOND
      |=> ext_valid_out && (dw_fault_out == ($past(in_opc) != 8'h00));
  endproperty
  a_second_hi_zero: assert property (p_second_hi_zero)
    else $error("second word upper bits check wrong");

  property p_lone_nop;
    issue && in_opc == ifcd_pkg::OPC_NOP
      |=> nop_out && done_out && cycles_out == 2'h1 && flag_mask_out == 5'h00;
  endproperty
  a_lone_nop: assert property (p_lone_nop)
    else $error("lone second word did more than a no-operation");

  property p_cond_true_two;
    issue && dec_if.is_cond_br && cond_true_in
      |=> state_ff == ST_FLUSH && left_ff == 2'h1 && !done_out;
  endproperty
  a_cond_true_two: assert property (p_cond_true_two)
    else $error("true condition did not add one cycle");

  property p_return_three;
    issue && (in_opc == ifcd_pkg::OPC_RETURN || in_opc == ifcd_pkg::OPC_RETURN_FROM_INTERRUPT_INSTR)
      |=> state_ff == ST_FLUSH && left_ff == 2'h2;
  endproperty
  a_return_three: assert property (p_return_three)
    else $error("return not scheduled for three cycles");

  property p_skip_double;
    step && state_ff == ST_SKIP && dec_if.is_double
      |=> state_ff == ST_SKIP_DW && nop_out && !done_out;
  endproperty
  a_skip_double: assert property (p_skip_double)
    else $error("skip over double word not three cycles");

  property p_double_two;
    step && state_ff == ST_SECOND |=> done_out && cycles_out == 2'h2;
  endproperty
  a_double_two: assert property (p_double_two)
    else $error("double-word instruction not two cycles");

  property p_lit_dest;
    exec_out && category_out == ifcd_pkg::CAT_LITERAL && opcode_out[4]
      |-> lit_wr_dst_out == (dst_reg_out != base_reg_out || dst_mode_out != 2'h0);
  endproperty
  a_lit_dest: assert property (p_lit_dest)
    else $error("literal destination write enable wrong");

  c_skip_over_double: cover property (done_out && cycles_out == 2'h3 &&
                                      $past(state_ff) == ST_SKIP_DW);
  c_double_word: cover property (ext_valid_out && done_out);
  c_return: cover property (exec_out && opcode_out == ifcd_pkg::OPC_RETURN_FROM_INTERRUPT_INSTR);
endmodule // ifcd_decoder
`default_nettype wire

// ===== testbench/ifcd_prog_mem.sv
// Program memory model streaming one word per fetch
// Assumes the bench loads mem, cnd and len before reset ends
`timescale 1ns/1ps
`default_nettype none
module ifcd_prog_mem (
  // Clock, reset, enable
  input  wire logic        clk_sys_in,
  input  wire logic        reset_in,
  input  wire logic        clk_en_in,
  input  wire logic        stall_in,
  // Word stream
  output logic [23:0]      insn_word_out,
  output logic             insn_valid_out,
  output logic             cond_true_out
);
  logic [23:0] mem [0:2047];
  logic        cnd [0:2047];
  int          len = 0;
  int          ptr = 0;
  initial begin
    insn_word_out  = 24'h000000;
    insn_valid_out = 1'b0;
    cond_true_out  = 1'b0;
  end
  // Advance only when the word was taken
  always @(posedge clk_sys_in) begin
    if (!reset_in && clk_en_in && insn_valid_out) ptr <= ptr + 1;
  end
  // Idle bus inverts every bit each cycle, so it alternates between inverted junk and the last word
  always @(negedge clk_sys_in) begin
    insn_valid_out <= !stall_in && ptr < len;
    insn_word_out  <= (!stall_in && ptr < len) ? mem[ptr] : ~insn_word_out;
    cond_true_out  <= (!stall_in && ptr < len) ? cnd[ptr] : ~cond_true_out;
  end
endmodule // ifcd_prog_mem
`default_nettype wire

// ===== testbench/tb.sv
// Self-checking bench: random program, field and cycle checks
// Assumes memory model stalls and enable gaps come from the bench
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic clk_sys_in = 1'b0, reset_in = 1'b1, clk_en_in = 1'b0, stall = 1'b1;
  logic [23:0] word;
  logic valid, cond, exec, nop, done, extv, fault, dfile, bfr, bmode, slot, lwd;
  logic [1:0] cyc, smode, dmode, tmode;
  logic [3:0] base, src, dst, bpos;
  logic [4:0] flags;
  logic [7:0] opc;
  logic [12:0] faddr;
  logic [15:0] extw, lit;
  logic [22:0] paddr;
  ifcd_pkg::ifcd_cat_type cat;
  logic [31:0] seed = 32'hF35874F9;
  logic [23:0] q_ins[$];
  logic [1:0] q_cyc[$];
  logic [39:0] q_ext[$];
  int num_errors = 0, n_compared = 0, n = 0, nop_exp = 0, nop_seen = 0, n_slot = 0;
  localparam logic [7:0] OPS [0:20] = '{8'h00, 8'h01, 8'h02, 8'h03, 8'h04, 8'h05, 8'h06,
    8'h07, 8'h08, 8'h09, 8'h0A, 8'h0B, 8'h0C, 8'h40, 8'h50, 8'hA0, 8'hB0, 8'hC0,
    8'h80, 8'h81, 8'h90};
  always #12.5 clk_sys_in = ~clk_sys_in;
  ifcd_prog_mem u_mem (.clk_sys_in(clk_sys_in), .reset_in(reset_in), .clk_en_in(clk_en_in),
    .stall_in(stall), .insn_word_out(word), .insn_valid_out(valid), .cond_true_out(cond));
  ifcd_decoder u_dut (.clk_sys_in(clk_sys_in), .reset_in(reset_in), .clk_en_in(clk_en_in),
    .insn_word_in(word), .insn_valid_in(valid), .cond_true_in(cond), .slot_valid_out(slot),
    .exec_out(exec), .nop_out(nop), .done_out(done), .cycles_out(cyc), .ext_valid_out(extv),
    .ext_word_out(extw), .prog_addr_out(paddr), .dw_fault_out(fault), .category_out(cat),
    .opcode_out(opc), .base_reg_out(base), .src_reg_out(src), .src_mode_out(smode),
    .dst_reg_out(dst), .dst_mode_out(dmode), .file_addr_out(faddr), .dest_is_file_out(dfile),
    .bit_pos_out(bpos), .bit_from_reg_out(bfr), .literal_out(lit), .lit_wr_dst_out(lwd),
    .table_mode_out(tmode), .flag_mask_out(flags), .byte_mode_out(bmode));
  function logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  task chk(input logic [63:0] got, input logic [63:0] exp);
    n_compared++;
    if (got !== exp) begin
      num_errors++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task put(input logic [23:0] w, input logic c);
    u_mem.mem[n] = w;
    u_mem.cnd[n] = c;
    n++;
  endtask
  task gen(input logic [7:0] op, input logic c, input logic alt);
    logic [31:0] r;
    logic [23:0] w, s;
    logic [1:0] k;
    r = rnd();
    w = {op, r[15:0]};
    put(w, c);
    q_ins.push_back(w);
    k = (op inside {8'h06, 8'h07}) ? 2'h3 : (op inside {8'h01, 8'h02, 8'h04, 8'h05, 8'h08,
      8'h09} || (op == 8'h03 && c)) ? 2'h2 : 2'h1;
    if (op == 8'h00) nop_exp++;
    if (ifcd_pkg::ifcd_is_double(op)) begin
      s = {alt ? (r[23:16] | 8'h01) : 8'h00, r[31:16]};
      put(s, 1'b0);
      q_ext.push_back({w[15:0], s});
      k = 2'h2;
    end else if (op == 8'hB0 && c) begin
      put({alt ? 8'h0B : 8'h40, r[31:16]}, 1'b0);
      if (alt) put({8'h00, r[15:0]}, 1'b0);
      k = alt ? 2'h3 : 2'h2;
      nop_exp += alt ? 2 : 1;
    end else begin
      for (int i = 1; i < k; i++) put({8'h40, r[31:16]}, 1'b0);
      nop_exp += k - 1;
    end
    q_cyc.push_back(k);
  endtask
  task chk_exec();
    logic [23:0] w;
    w = q_ins.pop_front();
    chk(opc, w[23:16]);
    case (w[23:22])
      2'h1: begin
        chk({cat, flags}, {ifcd_pkg::CAT_WORD_BYTE, 5'h1F});
        if (w[20]) chk({faddr, dfile, bmode}, {w[12:0], w[15], w[14]});
        else chk({base, dmode, dst, smode, src}, w[15:0]);
      end
      2'h2: begin
        if (w[21]) begin
          chk({cat, flags, bpos, bfr}, {ifcd_pkg::CAT_BIT, 5'h10, w[15:12], w[11]});
          chk({dfile, faddr}, {w[10], 3'h0, w[9:0]});
        end else if (w[20]) begin
          chk({cat, flags, lit}, {ifcd_pkg::CAT_LITERAL, 5'h1F, 10'h000, w[5:0]});
          chk(lwd, (w[9:6] != w[15:12]) || (w[11:10] != 2'h0));
        end else if (w[16]) begin
          chk({cat, flags, dfile}, {ifcd_pkg::CAT_LITERAL, 5'h00, 1'b1});
          chk({faddr, lit}, {5'h00, w[7:0], 8'h00, w[15:8]});
        end else begin
          chk({cat, flags}, {ifcd_pkg::CAT_LITERAL, 5'h00});
          chk({base, lit}, {w[3:0], 4'h0, w[15:4]});
        end
      end
      2'h3: chk({cat, flags}, {ifcd_pkg::CAT_DSP, 5'h1F});
      default: begin
        chk({cat, flags, lit}, {ifcd_pkg::CAT_CONTROL, 5'h00, w[15:0]});
        chk(tmode, (w[23:17] == 7'h04) ? w[15:14] : 2'h0);
      end
    endcase
  endtask
  always @(posedge clk_sys_in) begin
    if (clk_en_in && !reset_in) begin
      if (exec) chk_exec();
      if (done) chk(cyc, q_cyc.pop_front());
      if (extv) chk({extw, paddr, fault}, {q_ext[0][15:0], q_ext[0][6:0], q_ext[0][39:24],
        |q_ext[0][23:16]});
      if (extv) void'(q_ext.pop_front());
      if (nop) nop_seen++;
      if (slot) n_slot++;
    end
  end
  always @(negedge clk_sys_in) begin
    logic [31:0] r;
    r = rnd();
    clk_en_in <= r[2:0] != 3'h0;
    stall <= r[4:3] == 2'h0;
  end
  task wrap_up();
    $display("errors %0d compared %0d", num_errors, n_compared);
    if (num_errors == 0 && n_compared > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  initial begin
    #(25 * 30000);
    num_errors++;
    wrap_up();
  end
  initial begin
    logic [31:0] r;
    for (int i = 0; i < 21; i++) gen(OPS[i], 1'b1, i[0]);
    gen(8'h03, 1'b0, 1'b0);
    gen(8'hB0, 1'b1, 1'b1);
    gen(8'hB0, 1'b1, 1'b0);
    gen(8'h0C, 1'b0, 1'b0);
    for (int i = 0; i < 300; i++) begin
      r = rnd();
      gen(OPS[r[7:0] % 21], r[8], r[9]);
    end
    u_mem.len = n;
    repeat (2) @(posedge clk_sys_in);
    @(negedge clk_sys_in) reset_in = 1'b0;
    for (int i = 0; i < 20000 && (u_mem.ptr < n || q_cyc.size() > 0); i++) @(posedge clk_sys_in);
    repeat (8) @(posedge clk_sys_in);
    chk(nop_seen, nop_exp);
    chk(q_cyc.size() + q_ins.size() + q_ext.size(), 0);
    chk(n_slot, n);
    wrap_up();
  end
endmodule // tb
`default_nettype wire
